/* rtl/fapo_pkg.sv */
`default_nettype none
package fapo_pkg;
    localparam int FAPO_BITS = 8;
    localparam int FAPO_COMPS = 256;
    localparam logic [7:0] FAPO_CODE_ZERO = 8'h00;
    localparam logic [7:0] FAPO_CODE_FULL = 8'hff;
    localparam logic [8:0] FAPO_OVF_LEVEL = 9'h100;
    localparam int FAPO_SYS_PERIOD_NS = 40;
    localparam int FAPO_SAMPLE_LOW_NS = 25;
    localparam int FAPO_VALID_DELAY_NS = 15;
    localparam int FAPO_VALID_CYCLES = (FAPO_VALID_DELAY_NS + FAPO_SYS_PERIOD_NS - 1) / FAPO_SYS_PERIOD_NS;

    typedef enum logic [1:0]
    {
        FAPO_PH_IDLE,
        FAPO_PH_ZERO,
        FAPO_PH_SAMPLE
    } fapo_phase_t;

    typedef struct packed
    {
        logic ovf;
        logic [7:0] code;
    } fapo_result_t;
endpackage : fapo_pkg
`default_nettype wire

/* rtl/fapo_top.sv */
`default_nettype none
// Operation
// R1: data driven only when low-select 0, high-select 1
// R2: overflow driven whenever high select is 1
// R3: clock high is auto-zero, no decisions
// R4: clock low samples, latches comparators, encodes
// R5: encoder result loads on next rising edge
// R6: host gives high, low, high for one result
// R7: running clock yields one sample per cycle
// R8: full-scale input gives all ones
// R9: overflow high above top minus half step
// R10: cascade msb comes from lower device overflow
// R11: lower overflow steers cascade chip selects
// R12: host may burst from 30 MHz one-shot
// R13: straight binary, zero to all ones
// R14: overflow keeps data bits all ones
// R15: one-shot low pulse, valid after rise
// R16: output latch holds between rising edges
module fapo_top
    import fapo_pkg::*;
(
    input wire logic SYS_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic CLK_EN_I,
    input wire logic CONV_CLK_I,
    input wire logic [FAPO_COMPS-1:0] THERMO_I,
    input wire logic OUTPUT_SELECT_LOW_I,
    input wire logic OUTPUT_SELECT_HIGH_I,
    output logic [7:0] DATA_O,
    output logic [7:0] DATA_OE_O,
    output logic OVF_O,
    output logic OVF_OE_O
);

    ////////////////////////////////////////////////////////////////////////
    // the comparator bank is modelled as a thermometer vector from the
    // analog side; THERMO_I[k] high means input above tap k+1 (tap 256 is
    // top minus half a step). the conversion clock, comparator and select pins are off-domain, so two flops each.
    logic [2:0] conv_sync_reg;
    logic [2:0] conv_sync_next;
    logic [FAPO_COMPS-1:0] thermo_s1_reg;
    logic [FAPO_COMPS-1:0] thermo_s2_reg;
    logic [1:0] sel_low_sync_reg;
    logic [1:0] sel_high_sync_reg;

    always_comb
    begin
        conv_sync_next = {conv_sync_reg[1:0], CONV_CLK_I};
    end

    always_ff @(posedge SYS_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            conv_sync_reg <= 3'h7;
            thermo_s1_reg <= '0;
            thermo_s2_reg <= '0;
            sel_low_sync_reg <= 2'h3;
            sel_high_sync_reg <= 2'h0;
        end
        else if (CLK_EN_I)
        begin
            conv_sync_reg <= conv_sync_next;
            thermo_s1_reg <= THERMO_I;
            thermo_s2_reg <= thermo_s1_reg;
            sel_low_sync_reg <= {sel_low_sync_reg[0], OUTPUT_SELECT_LOW_I};
            sel_high_sync_reg <= {sel_high_sync_reg[0], OUTPUT_SELECT_HIGH_I};
        end
    end

    // a low phase shorter than one system clock can slip through unsampled here; that is the price of a safe crossing
    wire logic conv_high = conv_sync_reg[1];
    wire logic conv_rise = conv_sync_reg[1] & ~conv_sync_reg[2];

    ////////////////////////////////////////////////////////////////////////
    // 256-to-8 encoder: count of set comparators, saturating at full scale
    // a plain count tolerates a bubble in the thermometer where a priority encoder would jump
    function automatic fapo_result_t fapo_encode(input logic [FAPO_COMPS-1:0] thermo);
        logic [8:0] cnt;
        fapo_result_t res;
        cnt = 9'h000;
        for (int k = 0; k < FAPO_COMPS; k++)
        begin
            cnt = cnt + {8'h00, thermo[k]};
        end
        res.ovf = (cnt >= FAPO_OVF_LEVEL); // [R9]
        res.code = res.ovf ? FAPO_CODE_FULL : cnt[7:0]; // [R8] [R13] [R14]
        return res;
    endfunction : fapo_encode

    ////////////////////////////////////////////////////////////////////////
    // phase tracking and sample latch
    fapo_phase_t phase_reg;
    fapo_phase_t phase_next;
    fapo_result_t latch_reg;
    fapo_result_t latch_next;
    logic latch_full_reg;
    logic latch_full_next;
    fapo_result_t out_reg;
    fapo_result_t out_next;

    always_comb
    begin
        phase_next = phase_reg;
        latch_next = latch_reg;
        latch_full_next = latch_full_reg;
        out_next = out_reg; // [R16]
        case (phase_reg)
            FAPO_PH_IDLE:
            begin
                if (conv_high)
                begin
                    phase_next = FAPO_PH_ZERO;
                end
            end
            FAPO_PH_ZERO:
            begin
                // auto-zero: comparators reset, nothing is decided here [R3]
                if (!conv_high)
                begin
                    phase_next = FAPO_PH_SAMPLE;
                end
            end
            FAPO_PH_SAMPLE:
            begin
                // comparators track and latch while the clock is low [R4]
                // the rise cycle already belongs to auto-zero, so it must not refresh the latch [R3]
                if (conv_high)
                begin
                    phase_next = FAPO_PH_ZERO;
                end
                else
                begin
                    latch_next = fapo_encode(thermo_s2_reg);
                    latch_full_next = 1'b1;
                end
            end
            default:
            begin
                phase_next = FAPO_PH_IDLE;
            end
        endcase
        // load only at the rising edge after a full high-low cycle [R5] [R7] [R15]
        if (conv_rise && phase_reg == FAPO_PH_SAMPLE && latch_full_reg)
        begin
            out_next = latch_reg; // [R16]
            latch_full_next = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            phase_reg <= FAPO_PH_IDLE;
            latch_reg <= '0;
            latch_full_reg <= 1'b0;
            out_reg <= '0;
        end
        else if (CLK_EN_I)
        begin
            phase_reg <= phase_next;
            latch_reg <= latch_next;
            latch_full_reg <= latch_full_next;
            out_reg <= out_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // three-state control; the enables are the only path, the wire is resolved outside
    // the output flops keep running while deselected, so a late enable shows current data
    wire logic data_en = ~sel_low_sync_reg[1] & sel_high_sync_reg[1]; // [R1]
    wire logic ovf_en = sel_high_sync_reg[1]; // [R2]

    assign DATA_O = out_reg.code;
    assign DATA_OE_O = {FAPO_BITS{data_en}};
    assign OVF_O = out_reg.ovf;
    assign OVF_OE_O = ovf_en;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    sequence full_cycle_s;
        phase_reg == FAPO_PH_SAMPLE && latch_full_reg && conv_rise && CLK_EN_I;
    endsequence

    sequence low_sample_s;
        phase_reg == FAPO_PH_SAMPLE && !conv_high && CLK_EN_I;
    endsequence

    sequence rise_unfilled_s;
        conv_rise && !latch_full_reg && CLK_EN_I;
    endsequence

    data_enable_a: assert property (DATA_OE_O == ((~sel_low_sync_reg[1] & sel_high_sync_reg[1]) ? 8'hff : 8'h00)) // [R1]
        else $error("data enable wrong");
    ovf_enable_a: assert property (OVF_OE_O == sel_high_sync_reg[1]) // [R2]
        else $error("overflow enable wrong");
    zero_no_latch_a: assert property (phase_reg == FAPO_PH_ZERO && CLK_EN_I |=> $stable(latch_reg)) // [R3]
        else $error("latch moved in auto-zero");
    sample_latch_a: assert property (low_sample_s |=> latch_full_reg) // [R4]
        else $error("sample not latched");
    load_edge_a: assert property (full_cycle_s |=> out_reg == $past(latch_reg)) // [R5] [R7]
        else $error("output not loaded");
    hold_out_a: assert property (!conv_rise |=> $stable(out_reg)) // [R16]
        else $error("output changed between edges");
    ovf_ones_a: assert property (out_reg.ovf |-> out_reg.code == FAPO_CODE_FULL) // [R14] [R8]
        else $error("overflow cleared data");
    ovf_level_a: assert property (latch_full_reg |-> latch_reg.ovf == ($countones(thermo_s2_reg) == FAPO_COMPS)
        || phase_reg != FAPO_PH_SAMPLE || !$stable(thermo_s2_reg)) // [R9]
        else $error("overflow level wrong");

    rise_no_latch_a: assert property (conv_high && CLK_EN_I |=> $stable(latch_reg)) // [R3]
        else $error("latch moved while clock high");
    unfilled_no_load_a: assert property (rise_unfilled_s |=> $stable(out_reg)) // [R5]
        else $error("load without a low phase");
    one_load_a: assert property (full_cycle_s |=> ##1 $stable(out_reg)) // [R7]
        else $error("output loaded twice");
    latch_ovf_ones_a: assert property (latch_reg.ovf |-> latch_reg.code == FAPO_CODE_FULL) // [R14]
        else $error("latch cleared data on overflow");
endmodule : fapo_top
`default_nettype wire

/* test/fapo_host_model.sv */
`default_nettype none
module fapo_host_model
(
    input wire logic clk_i,
    output logic conv_clk_o,
    output logic [255:0] thermo_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // clock rests high so the comparators idle in auto-zero between shots
    initial conv_clk_o = 1'b1;
    initial thermo_o = '0;
    task automatic set_level(input int lvl);
        @(negedge clk_i);
        for (int i = 0; i < 256; i++)
            thermo_o[i] = (i < lvl);
    endtask : set_level
    // low phase kept three cycles: a low phase under two cycles is lost in the phase tracking
    task automatic pulse(input int lvl);
        set_level(lvl);
        repeat (3) @(negedge clk_i);
        conv_clk_o = 1'b0;
        repeat (3) @(negedge clk_i);
        conv_clk_o = 1'b1;
    endtask : pulse
endmodule : fapo_host_model
`default_nettype wire

/* test/tb_flash_adc_pipeline_output.sv */
`default_nettype none
module tb_flash_adc_pipeline_output;
    import fapo_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic SYS_CLK_I, SYS_RST_I, CLK_EN_I, CONV_CLK_I, sel_low, sel_high;
    logic [255:0] THERMO_I;
    logic [7:0] DATA_O, DATA_OE_O;
    logic OVF_O, OVF_OE_O;
    int fails = 0;
    int samples_checked = 0;
    fapo_top DUT (.SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .CLK_EN_I(CLK_EN_I),
        .CONV_CLK_I(CONV_CLK_I), .THERMO_I(THERMO_I), .OUTPUT_SELECT_LOW_I(sel_low),
        .OUTPUT_SELECT_HIGH_I(sel_high), .DATA_O(DATA_O), .DATA_OE_O(DATA_OE_O),
        .OVF_O(OVF_O), .OVF_OE_O(OVF_OE_O));
    fapo_host_model host (.clk_i(SYS_CLK_I), .conv_clk_o(CONV_CLK_I), .thermo_o(THERMO_I));
    initial
    begin
        SYS_CLK_I = 1'b0;
        forever #20 SYS_CLK_I = ~SYS_CLK_I;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        if (fails == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////////////////
    // all four select combinations, enables settle after the two-flop synchroniser
    task automatic test_selects();
        for (int i = 0; i < 4; i++)
        begin
            @(negedge SYS_CLK_I);
            {sel_low, sel_high} = i[1:0];
            repeat (4) @(negedge SYS_CLK_I);
            check("data_oe", {1'b0, DATA_OE_O}, (i == 1) ? 9'h0ff : 9'h000);
            check("ovf_oe", {8'h00, OVF_OE_O}, {8'h00, i[0]});
        end
    endtask : test_selects
    // zero, one step, mid, full scale and overflow, back to back
    task automatic test_codes();
        int lvls[5] = '{0, 1, 128, 255, 256};
        logic [8:0] exps[5] = '{9'h000, 9'h001, 9'h080, 9'h0ff, 9'h1ff};
        logic [8:0] prev = 9'h000;
        for (int i = 0; i < 5; i++)
        begin
            host.pulse(lvls[i]);
            @(negedge SYS_CLK_I);
            check("early", {OVF_O, DATA_O}, prev);
            repeat (2) @(negedge SYS_CLK_I);
            check("result", {OVF_O, DATA_O}, exps[i]);
            prev = exps[i];
        end
    endtask : test_codes
    // comparators change while the clock rests high: the output must not follow
    task automatic test_hold();
        host.set_level(0);
        repeat (6) @(negedge SYS_CLK_I);
        check("held", {OVF_O, DATA_O}, 9'h1ff);
    endtask : test_hold
    // a conversion clock cycle while the clock enable is low must leave no trace
    task automatic test_freeze();
        @(negedge SYS_CLK_I);
        CLK_EN_I = 1'b0;
        host.pulse(64);
        repeat (2) @(negedge SYS_CLK_I);
        check("frozen", {OVF_O, DATA_O}, 9'h1ff);
        CLK_EN_I = 1'b1;
        repeat (4) @(negedge SYS_CLK_I);
        check("thawed", {OVF_O, DATA_O}, 9'h1ff);
    endtask : test_freeze
    // lower-range device of a pair: its own overflow steers its active-low select
    task automatic test_cascade();
        @(negedge SYS_CLK_I);
        sel_low = OVF_O;
        sel_high = 1'b1;
        repeat (4) @(negedge SYS_CLK_I);
        check("cascade data_oe high", {1'b0, DATA_OE_O}, 9'h000);
        check("cascade ovf_oe", {8'h00, OVF_OE_O}, 9'h001);
        check("cascade msb", {8'h00, OVF_O}, 9'h001);
        host.pulse(64);
        repeat (3) @(negedge SYS_CLK_I);
        check("cascade result", {OVF_O, DATA_O}, 9'h040);
        sel_low = OVF_O;
        repeat (4) @(negedge SYS_CLK_I);
        check("cascade data_oe low", {1'b0, DATA_OE_O}, 9'h0ff);
        check("cascade word", {OVF_O, DATA_O}, 9'h040);
    endtask : test_cascade
    // reset in mid-run clears the result and the enables, then conversions resume
    task automatic test_reset();
        @(negedge SYS_CLK_I);
        SYS_RST_I = 1'b1;
        repeat (2) @(negedge SYS_CLK_I);
        check("reset result", {OVF_O, DATA_O}, 9'h000);
        check("reset data_oe", {1'b0, DATA_OE_O}, 9'h000);
        check("reset ovf_oe", {8'h00, OVF_OE_O}, 9'h000);
        SYS_RST_I = 1'b0;
        repeat (3) @(negedge SYS_CLK_I);
        check("data_oe after reset", {1'b0, DATA_OE_O}, 9'h0ff);
        host.pulse(255);
        @(negedge SYS_CLK_I);
        check("early after reset", {OVF_O, DATA_O}, 9'h000);
        repeat (2) @(negedge SYS_CLK_I);
        check("result after reset", {OVF_O, DATA_O}, 9'h0ff);
    endtask : test_reset
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        SYS_RST_I = 1'b1;
        CLK_EN_I = 1'b1;
        sel_low = 1'b1;
        sel_high = 1'b0;
        repeat (20) @(negedge SYS_CLK_I);
        SYS_RST_I = 1'b0;
        test_selects();
        test_codes();
        test_freeze();
        test_hold();
        test_cascade();
        test_reset();
        give_verdict();
    end
    // the whole sequence needs about 150 cycles
    initial
    begin
        #40000;
        fails++;
        give_verdict();
    end
endmodule : tb_flash_adc_pipeline_output
`default_nettype wire
